// file: hdl/lane_defs.vh
// constants for the data lane signalling block
`ifndef LANE_DEFS_VH
`define LANE_DEFS_VH
// mode register five fields (address bit positions)
`define MODE5_MASK_BIT 10
`define MODE5_WINV_BIT 11
`define MODE5_RINV_BIT 12
// mode register one field: termination strobe enable
`define MODE1_TERM_BIT 11
// component width codes
`define WIDTH_X4 2'b00
`define WIDTH_X8 2'b01
`define WIDTH_X16 2'b10
// crc error low interval in clk cycles (default)
`define CRC_LOW_CYCLES 16'h0030
// width of a lane
`define LANE_W 4
// memory depth (address bits)
`define MEM_AW 4
`endif

// file: hdl/sync2.v
// two flip-flop synchroniser for one bit
module sync2 (
  input wire clk,
  input wire sys_rst,
  input wire d,
  output reg q
);
  reg meta_reg;
  // first stage feeds only the second
  always @(posedge clk) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // sync2

// file: hdl/lane_mem.v
// small lane memory with registered read data
module lane_mem (
  input wire clk,
  input wire we,
  input wire [3:0] waddr,
  input wire [3:0] wdata,
  input wire [3:0] raddr,
  output reg [3:0] rdata
);
  reg [3:0] mem [0:15];
  // write port and registered read
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // lane_mem

// file: hdl/dimm_lane.v
// data lane signalling of a nonvolatile registered memory module
// Operation
// [RULE1] masked write beat leaves location unchanged
// [RULE2] mask sampled on both strobe edges
// [RULE3] shared pin mode from mode register five
// [RULE4] inversion low means data inverted
// [RULE5] device drives strobe edge-aligned on reads
// [RULE6] differential strobe pair only
// [RULE7] each strobe pair qualifies lines 3..0
// [RULE8] crc error pulls alert low, fixed time
// [RULE9] parity error holds alert until recovery
// [RULE10] test mode: alert pin is input
// [RULE11] thermal trip drives event low
// [RULE12] save low switches muxes, copies to flash
// [RULE13] host enters self refresh before save
// [RULE14] termination strobe gets same termination
// [RULE15] disabled: true pin masks, comp unused
// [RULE16] keep term strobe off for x4/x16
// [RULE17] mask only for x8 and x16
// [RULE18] crc code follows last burst beat; the read path sends no crc beat
// [RULE19] crc low interval is a parameter
`include "lane_defs.vh"
module dimm_lane #(
  parameter [15:0] CRC_LOW = `CRC_LOW_CYCLES
) (
  input wire clk,
  input wire sys_rst,
  input wire [15:0] mode_reg_five,
  input wire [15:0] mode_reg_one,
  input wire [1:0] comp_width,
  input wire strobe_t_in,
  input wire strobe_c_in,
  output reg strobe_t_out,
  output reg strobe_c_out,
  output reg strobe_oe,
  input wire [3:0] dq_in,
  output reg [3:0] dq_out,
  output reg dq_oe,
  input wire write_mask_n,
  output reg bus_invert_n_out,
  output reg bus_invert_oe,
  input wire wr_en,
  input wire [3:0] wr_addr,
  input wire rd_req,
  input wire [3:0] rd_addr,
  input wire [2:0] burst_len,
  input wire crc_err,
  input wire parity_err,
  input wire recovery_done,
  input wire conn_test,
  input wire alert_n_in,
  output reg alert_n_out,
  output reg alert_n_oe,
  output reg alert_in_seen,
  input wire over_temp,
  output reg event_n,
  input wire save_n,
  output reg host_mux_off,
  output reg save_busy,
  output reg [3:0] flash_addr,
  output reg [3:0] flash_data,
  output reg flash_we,
  output reg term_strobe_true,
  output reg term_strobe_comp,
  output reg term_strobe_oe,
  output reg term_on
);
  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  wire st_s, sc_s, wm_s, save_act_s, alert_act_s, temp_s;
  // save and alert pins synced inverted so the reset value reads as idle, no false save
  wire save_s = ~save_act_s;
  wire alert_s = ~alert_act_s;
  wire [3:0] dq_s;
  sync2 u_st (.clk(clk), .sys_rst(sys_rst), .d(strobe_t_in), .q(st_s));
  sync2 u_sc (.clk(clk), .sys_rst(sys_rst), .d(strobe_c_in), .q(sc_s));
  sync2 u_wm (.clk(clk), .sys_rst(sys_rst), .d(write_mask_n), .q(wm_s));
  sync2 u_sv (.clk(clk), .sys_rst(sys_rst), .d(~save_n), .q(save_act_s));
  sync2 u_al (.clk(clk), .sys_rst(sys_rst), .d(~alert_n_in), .q(alert_act_s));
  sync2 u_tp (.clk(clk), .sys_rst(sys_rst), .d(over_temp), .q(temp_s));
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_dq
      // each strobe pair qualifies lines 3..0 of its component
      sync2 u_dq (.clk(clk), .sys_rst(sys_rst), .d(dq_in[gi]), .q(dq_s[gi])); // [RULE7]
    end
  endgenerate

  // -------------------------------------------------------------
  // mode decode
  // -------------------------------------------------------------
  wire is_x4 = (comp_width == `WIDTH_X4);
  // mask only in x8/x16 and only while termination strobe is off
  wire tdqs_en = mode_reg_one[`MODE1_TERM_BIT] & (comp_width == `WIDTH_X8); // [RULE16]
  wire dm_en = mode_reg_five[`MODE5_MASK_BIT] & ~is_x4 & ~tdqs_en; // [RULE3] [RULE17] [RULE15]
  wire wdbi_en = mode_reg_five[`MODE5_WINV_BIT] & ~dm_en & ~is_x4; // [RULE3]
  wire rdbi_en = mode_reg_five[`MODE5_RINV_BIT] & ~is_x4; // [RULE3]

  // -------------------------------------------------------------
  // strobe edge detect on the differential pair
  // -------------------------------------------------------------
  reg diff_reg;
  // true minus complement: a valid pair has opposite levels
  wire diff_now = st_s & ~sc_s; // [RULE6]
  wire pair_ok = st_s ^ sc_s; // [RULE6]
  wire strobe_edge = pair_ok & (diff_now != diff_reg); // [RULE2]
  always @(posedge clk) begin
    if (sys_rst) begin
      diff_reg <= 1'b0;
    end else if (pair_ok) begin
      diff_reg <= diff_now;
    end
  end

  // -------------------------------------------------------------
  // write path: one beat per strobe edge
  // -------------------------------------------------------------
  reg [3:0] waddr_reg;
  wire [3:0] wbeat = (wdbi_en & ~wm_s) ? ~dq_s : dq_s; // [RULE4]
  // with masking on, a beat with mask low is dropped, the address still advances
  wire mem_we = wr_en & strobe_edge & ~(dm_en & ~wm_s); // [RULE1] [RULE2]
  always @(posedge clk) begin
    if (sys_rst) begin
      waddr_reg <= 4'h0;
    end else if (!wr_en) begin
      waddr_reg <= wr_addr;
    end else if (strobe_edge) begin
      waddr_reg <= waddr_reg + 4'h1;
    end
  end

  // -------------------------------------------------------------
  // save copy state and shared memory read port
  // -------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_COPY = 3'b010;
  localparam [2:0] S_DONE = 3'b100;
  reg [2:0] save_reg;
  reg [2:0] save_next;
  reg [4:0] copy_cnt_reg;
  reg copy_vld_reg;
  reg [3:0] rd_ptr_reg;
  wire [3:0] mem_rdata;
  wire [3:0] mem_raddr = (save_reg == S_COPY) ? copy_cnt_reg[3:0] : rd_ptr_reg;
  lane_mem u_mem (
    .clk(clk),
    .we(mem_we & (save_reg == S_IDLE)),
    .waddr(waddr_reg),
    .wdata(wbeat),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );
  // save low switches away from host and copies every location
  always @* begin
    case (save_reg)
      S_IDLE: save_next = save_s ? S_IDLE : S_COPY; // [RULE12]
      S_COPY: save_next = copy_cnt_reg[4] ? S_DONE : S_COPY; // [RULE12]
      S_DONE: save_next = save_s ? S_IDLE : S_DONE;
      default: save_next = S_IDLE;
    endcase
  end
  // the host must have put the array in self refresh first; nothing guards it here
  always @(posedge clk) begin
    if (sys_rst) begin
      save_reg <= S_IDLE;
      copy_cnt_reg <= 5'h00;
      copy_vld_reg <= 1'b0;
      flash_we <= 1'b0;
      flash_addr <= 4'h0;
      flash_data <= 4'h0;
      host_mux_off <= 1'b0;
      save_busy <= 1'b0;
    end else begin
      save_reg <= save_next;
      copy_vld_reg <= (save_reg == S_COPY) & ~copy_cnt_reg[4];
      flash_we <= copy_vld_reg; // [RULE12]
      flash_addr <= copy_cnt_reg[3:0] - 4'h1;
      flash_data <= mem_rdata;
      host_mux_off <= (save_next != S_IDLE); // [RULE12]
      save_busy <= (save_next == S_COPY);
      if (save_reg == S_COPY) begin
        copy_cnt_reg <= copy_cnt_reg + 5'h01;
      end else begin
        copy_cnt_reg <= 5'h00;
      end
    end
  end

  // -------------------------------------------------------------
  // read path: device drives strobe with data, edge aligned
  // -------------------------------------------------------------
  reg [3:0] rd_left_reg;
  reg rd_phase_reg;
  always @(posedge clk) begin
    if (sys_rst) begin
      rd_left_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      rd_phase_reg <= 1'b0;
      strobe_t_out <= 1'b0;
      strobe_c_out <= 1'b1;
      strobe_oe <= 1'b0;
      dq_out <= 4'h0;
      dq_oe <= 1'b0;
      bus_invert_n_out <= 1'b1;
      bus_invert_oe <= 1'b0;
    end else if (rd_left_reg == 4'h0) begin
      strobe_oe <= 1'b0;
      dq_oe <= 1'b0;
      bus_invert_oe <= 1'b0;
      rd_phase_reg <= 1'b0;
      if (rd_req & ~host_mux_off) begin
        // burst_len plus one beats, all read data; no crc beat is sent
        rd_left_reg <= {1'b0, burst_len} + 4'h1; // [RULE18]
        rd_ptr_reg <= rd_addr;
      end
    end else begin
      // two clocks per beat: read data settles, then strobe toggles with it
      rd_phase_reg <= ~rd_phase_reg;
      if (rd_phase_reg) begin
        rd_left_reg <= rd_left_reg - 4'h1;
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
        strobe_t_out <= ~strobe_t_out; // [RULE5]
        strobe_c_out <= strobe_t_out; // [RULE6]
        strobe_oe <= 1'b1;
        dq_oe <= 1'b1;
        bus_invert_oe <= rdbi_en;
        // invert when more than two ones, flag it low
        if (rdbi_en & (mem_rdata[0] + mem_rdata[1] + mem_rdata[2] + mem_rdata[3] > 3'd2)) begin
          dq_out <= ~mem_rdata; // [RULE4]
          bus_invert_n_out <= 1'b0; // [RULE4]
        end else begin
          dq_out <= mem_rdata;
          bus_invert_n_out <= 1'b1;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // alert flag, open drain
  // -------------------------------------------------------------
  reg [15:0] crc_cnt_reg;
  reg par_hold_reg;
  always @(posedge clk) begin
    if (sys_rst) begin
      crc_cnt_reg <= 16'h0000;
      par_hold_reg <= 1'b0;
      alert_n_out <= 1'b0;
      alert_n_oe <= 1'b0;
      alert_in_seen <= 1'b1;
    end else begin
      if (crc_err) begin
        crc_cnt_reg <= CRC_LOW; // [RULE8] [RULE19]
      end else if (crc_cnt_reg != 16'h0000) begin
        crc_cnt_reg <= crc_cnt_reg - 16'h0001; // [RULE8]
      end
      // a new parity error wins over a recovery done
      if (parity_err) begin
        par_hold_reg <= 1'b1; // [RULE9]
      end else if (recovery_done) begin
        par_hold_reg <= 1'b0; // [RULE9]
      end
      alert_n_out <= 1'b0;
      // in test mode the pin is only listened to
      alert_n_oe <= ~conn_test & (crc_err | parity_err | (crc_cnt_reg > 16'h0001) |
        (par_hold_reg & ~recovery_done)); // [RULE8] [RULE9] [RULE10]
      alert_in_seen <= conn_test ? alert_s : 1'b1; // [RULE10]
    end
  end

  // -------------------------------------------------------------
  // temperature event and termination strobe
  // -------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      event_n <= 1'b1;
      term_on <= 1'b0;
      term_strobe_true <= 1'b0;
      term_strobe_comp <= 1'b0;
      term_strobe_oe <= 1'b0;
    end else begin
      event_n <= ~temp_s; // [RULE11]
      // same termination on the termination pair as on the strobe pair
      term_on <= tdqs_en & ~strobe_oe; // [RULE14]
      // strobe mirrors onto the termination pair on reads
      term_strobe_true <= tdqs_en & strobe_t_out; // [RULE14]
      term_strobe_comp <= tdqs_en & strobe_c_out; // [RULE15]
      term_strobe_oe <= tdqs_en & strobe_oe; // [RULE15]
    end
  end
endmodule // dimm_lane

// file: verif/dimm_lane_properties.sv
// concurrent checks on the ports of the data lane block
`include "lane_defs.vh"
module dimm_lane_properties #(
  parameter [15:0] CRC_LOW = 16'h0030
) (
  input wire clk,
  input wire sys_rst,
  input wire [15:0] mode_reg_one,
  input wire [1:0] comp_width,
  input wire strobe_t_out,
  input wire strobe_c_out,
  input wire strobe_oe,
  input wire [3:0] dq_out,
  input wire crc_err,
  input wire parity_err,
  input wire recovery_done,
  input wire conn_test,
  input wire alert_n_oe,
  input wire alert_in_seen,
  input wire over_temp,
  input wire event_n,
  input wire save_n,
  input wire host_mux_off,
  input wire term_on
);
  // slack of three cycles covers sync and register stages
  localparam int CRC_HI = CRC_LOW + 3;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // strobe, alert, event, save, termination
  // ----------------------------------------
  a_strobe_diff: assert property (strobe_oe |-> strobe_c_out == !strobe_t_out)
    else $error("read strobe pair not complementary");
  a_edge_aligned: assert property (strobe_oe && $past(strobe_oe) && $changed(dq_out)
    |-> $changed(strobe_t_out))
    else $error("read data moved without a strobe edge");
  a_crc_pull: assert property (crc_err |=> alert_n_oe [*3])
    else $error("crc alert not pulled low");
  a_crc_release: assert property (crc_err && !parity_err && !alert_n_oe
    |-> ##[2:CRC_HI] !alert_n_oe)
    else $error("crc alert not released in time");
  a_parity_hold: assert property (parity_err ##1 !recovery_done [*4] |-> alert_n_oe)
    else $error("parity alert dropped before recovery");
  a_parity_free: assert property (recovery_done && !crc_err |-> ##[1:CRC_HI] !alert_n_oe)
    else $error("parity alert kept after recovery");
  a_test_input: assert property (conn_test [*2] |-> !alert_n_oe)
    else $error("alert driven during connectivity test");
  a_test_seen: assert property (!conn_test [*2] |-> alert_in_seen)
    else $error("alert sense active outside test");
  a_temp_trip: assert property (over_temp [*5] |-> !event_n)
    else $error("thermal event not asserted");
  a_save_mux: assert property (!save_n [*5] |-> host_mux_off)
    else $error("host mux not switched away on save");
  a_term_on: assert property ((mode_reg_one[`MODE1_TERM_BIT] && comp_width == `WIDTH_X8) [*3]
    |-> term_on)
    else $error("termination strobe not terminated");
endmodule // dimm_lane_properties
bind dimm_lane dimm_lane_properties #(.CRC_LOW(CRC_LOW)) checks (.*);

// file: verif/host_model.sv
// host controller model driving write bursts onto the lane
module host_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] data,
  input wire logic [3:0] mask_n,
  output logic strobe_t_in,
  output logic strobe_c_in,
  output logic [3:0] dq_in,
  output logic write_mask_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] cnt = 7'h00;
  initial {strobe_t_in, strobe_c_in, dq_in, write_mask_n} = 7'h2f;
  // ----------------------------------------
  // burst engine: 4 beats, 8 clk half period
  // ----------------------------------------
  // data moves 4 clks before each strobe edge so the edge sits mid eye
  always @(posedge clk) begin
    if (go && cnt == 7'h00)
      cnt <= 7'h01;
    else if (cnt != 7'h00)
      cnt <= (cnt == 7'h24) ? 7'h00 : cnt + 7'h01;
    if (cnt[2:0] == 3'h1 && cnt < 7'h20) begin
      dq_in <= data[cnt[4:3]*4 +: 4];
      write_mask_n <= mask_n[cnt[4:3]];
    end
    // released lines show the inverse, not a stale value
    if (cnt == 7'h21)
      dq_in <= ~dq_in;
    // strobe stands still between bursts
    if (cnt[2:0] == 3'h5 && cnt < 7'h20) begin
      strobe_t_in <= ~strobe_t_in;
      strobe_c_in <= strobe_t_in;
    end
  end
endmodule // host_model

// file: verif/tb_dimm_lane.sv
// self-checking bench for the data lane block
`include "lane_defs.vh"
module tb_dimm_lane;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, rd_req = 1'b0, crc_err = 1'b0;
  logic parity_err = 1'b0, recovery_done = 1'b0, conn_test = 1'b0, over_temp = 1'b0;
  logic save_n = 1'b1, alert_drv = 1'b1, h_go = 1'b0;
  logic [15:0] mode_reg_five = 16'h0000, mode_reg_one = 16'h0000, h_data = 16'h0000;
  logic [3:0] wr_addr = 4'h0, rd_addr = 4'h0, h_mask = 4'hf;
  logic [2:0] burst_len = 3'h3;
  logic [1:0] comp_width = `WIDTH_X8;
  logic strobe_t_in, strobe_c_in, write_mask_n, strobe_t_out, strobe_c_out, strobe_oe, dq_oe;
  logic bus_invert_n_out, bus_invert_oe, alert_n_out, alert_n_oe, alert_in_seen, event_n;
  logic host_mux_off, save_busy, flash_we, term_strobe_true, term_strobe_comp;
  logic term_strobe_oe, term_on;
  logic [3:0] dq_in, dq_out, flash_addr, flash_data;
  int n_mismatch = 0, samples_checked = 0;
  // open-drain alert wire with pull-up
  wire alert_n_in = alert_n_oe ? alert_n_out : alert_drv;
  always #2.5 clk = ~clk;
  dimm_lane #(.CRC_LOW(16'h0004)) DUT (.*);
  host_model host (.clk(clk), .go(h_go), .data(h_data), .mask_n(h_mask),
    .strobe_t_in(strobe_t_in), .strobe_c_in(strobe_c_in), .dq_in(dq_in),
    .write_mask_n(write_mask_n));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // fixed wait: host frame is 36 clks plus write latency
  task automatic wr(input logic [15:0] d, input logic [3:0] m);
    h_data <= d;
    h_mask <= m;
    @(posedge clk);
    wr_en <= 1'b1;
    h_go <= 1'b1;
    @(posedge clk);
    h_go <= 1'b0;
    repeat (42) @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] e, input logic [3:0] f);
    int k;
    rd_req <= 1'b1;
    @(posedge clk);
    rd_req <= 1'b0;
    for (k = 0; k < 9 && strobe_oe !== 1'b1; k++) @(negedge clk);
    for (k = 0; k < 4; k++) begin
      chk(dq_out, e[k*4 +: 4]);
      chk(dq_oe, 1'b1);
      chk(bus_invert_oe, mode_reg_five[12]);
      if (mode_reg_five[12]) chk(bus_invert_n_out, f[k]);
      repeat (2) @(negedge clk);
    end
    @(posedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_data;
    mode_reg_five <= 16'h0400;
    wr(16'h1234, 4'hf);
    wr(16'habcd, 4'b1011);
    rd(16'ha2cd, 4'h0);
    comp_width <= `WIDTH_X4;
    wr(16'h9876, 4'h0);
    rd(16'h9876, 4'h0);
    comp_width <= `WIDTH_X8;
    mode_reg_five <= 16'h0800;
    wr(16'h5a3c, 4'b1010);
    mode_reg_five <= 16'h0000;
    rd(16'h5533, 4'h0);
    wr(16'hf731, 4'hf);
    mode_reg_five <= 16'h1000;
    rd(16'h0831, 4'b0011);
    $display("data tests done");
  endtask
  task automatic s_alert;
    crc_err <= 1'b1;
    @(posedge clk);
    crc_err <= 1'b0;
    @(negedge clk);
    chk(alert_n_in, 1'b0);
    repeat (8) @(negedge clk);
    chk(alert_n_oe, 1'b0);
    @(posedge clk);
    parity_err <= 1'b1;
    @(posedge clk);
    parity_err <= 1'b0;
    repeat (12) @(negedge clk);
    chk(alert_n_in, 1'b0);
    @(posedge clk);
    recovery_done <= 1'b1;
    @(posedge clk);
    recovery_done <= 1'b0;
    repeat (2) @(negedge clk);
    chk(alert_n_in, 1'b1);
    @(posedge clk);
    conn_test <= 1'b1;
    alert_drv <= 1'b0;
    repeat (5) @(negedge clk);
    chk(alert_in_seen, 1'b0);
    @(posedge clk);
    conn_test <= 1'b0;
    alert_drv <= 1'b1;
    $display("alert tests done");
  endtask
  task automatic s_misc;
    over_temp <= 1'b1;
    mode_reg_one <= 16'h0800;
    repeat (5) @(negedge clk);
    chk(event_n, 1'b0);
    chk(term_on, 1'b1);
    @(posedge clk);
    over_temp <= 1'b0;
    mode_reg_one <= 16'h0000;
    repeat (5) @(negedge clk);
    chk(event_n, 1'b1);
    chk(term_on, 1'b0);
    $display("misc tests done");
  endtask
  // host idles in self refresh before the save trigger
  task automatic s_save;
    int n;
    n = 0;
    @(posedge clk);
    save_n <= 1'b0;
    repeat (300) begin
      @(negedge clk);
      n += flash_we;
      if (flash_we && flash_addr == 4'h2) chk(flash_data, 4'h7);
    end
    chk(host_mux_off, 1'b1);
    chk(save_busy, 1'b0);
    chk(n, 16);
    $display("save test done");
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    s_data;
    s_alert;
    s_misc;
    s_save;
    print_verdict;
  end
  // run needs about 660 clks; limit allows about eighteen times that
  initial begin
    #60000;
    n_mismatch++;
    print_verdict;
  end
endmodule // tb_dimm_lane
